//--- include/tccirq_pkg.sv
// Constants, register map and state layout for the timer capture/compare and interrupt flag block
package tccirq_pkg;
    // Register indices; the APB byte address is four times the index
    localparam logic [7:0] TCCIRQ_IDX_CTRL_A   = 8'h2F;
    localparam logic [7:0] TCCIRQ_IDX_CTRL_B   = 8'h2E;
    localparam logic [7:0] TCCIRQ_IDX_MASK     = 8'h39;
    localparam logic [7:0] TCCIRQ_IDX_FLAGS    = 8'h38;
    localparam logic [7:0] TCCIRQ_IDX_CAPT_LO  = 8'h24;
    localparam logic [7:0] TCCIRQ_IDX_CAPT_HI  = 8'h25;
    localparam logic [7:0] TCCIRQ_IDX_CMPB_LO  = 8'h28;
    localparam logic [7:0] TCCIRQ_IDX_CMPB_HI  = 8'h29;
    localparam logic [7:0] TCCIRQ_IDX_CMPA_LO  = 8'h2A;
    localparam logic [7:0] TCCIRQ_IDX_CMPA_HI  = 8'h2B;

    // Reset values
    localparam logic [7:0]  TCCIRQ_RST_BYTE = 8'h00;
    localparam logic [15:0] TCCIRQ_RST_WORD = 16'h0000;

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] TCCIRQ_CTRL_A_RW = 8'hF3;
    localparam logic [7:0] TCCIRQ_CTRL_B_RW = 8'hCF;
    localparam logic [7:0] TCCIRQ_MASK_RW   = 8'hFD;
    localparam logic [7:0] TCCIRQ_FLAGS_RW  = 8'hFD;

    // Control A fields
    localparam int TCCIRQ_CMPA_MODE_HI = 7;
    localparam int TCCIRQ_CMPA_MODE_LO = 6;
    localparam int TCCIRQ_CMPB_MODE_HI = 5;
    localparam int TCCIRQ_CMPB_MODE_LO = 4;
    localparam int TCCIRQ_PWM_SEL_HI   = 1;
    localparam int TCCIRQ_PWM_SEL_LO   = 0;
    // Control B fields
    localparam int TCCIRQ_NOISE_EN     = 7;
    localparam int TCCIRQ_EDGE_SEL     = 6;

    // Flag and mask bit positions
    localparam int TCCIRQ_B_T2_CMP  = 7;
    localparam int TCCIRQ_B_T2_OVF  = 6;
    localparam int TCCIRQ_B_CAPTURE = 5;
    localparam int TCCIRQ_B_CMP_A   = 4;
    localparam int TCCIRQ_B_CMP_B   = 3;
    localparam int TCCIRQ_B_T1_OVF  = 2;
    localparam int TCCIRQ_B_T0_OVF  = 0;

    // Interrupt vector numbers per flag bit (bit 1 has none)
    localparam logic [3:0] TCCIRQ_VEC_NONE = 4'h0;
    localparam logic [3:0] TCCIRQ_VEC_TAB [8] = '{4'h9, 4'h0, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3};

    // Compare output modes
    localparam logic [1:0] TCCIRQ_OM_OFF    = 2'h0;
    localparam logic [1:0] TCCIRQ_OM_TOGGLE = 2'h1;
    localparam logic [1:0] TCCIRQ_OM_CLEAR  = 2'h2;
    localparam logic [1:0] TCCIRQ_OM_SET    = 2'h3;

    // PWM selections and counter width masks
    localparam logic [1:0]  TCCIRQ_PWM_OFF  = 2'h0;
    localparam logic [1:0]  TCCIRQ_PWM_8    = 2'h1;
    localparam logic [1:0]  TCCIRQ_PWM_9    = 2'h2;
    localparam logic [15:0] TCCIRQ_MASK_8   = 16'h00FF;
    localparam logic [15:0] TCCIRQ_MASK_9   = 16'h01FF;
    localparam logic [15:0] TCCIRQ_MASK_10  = 16'h03FF;

    // Noise filter length in samples
    localparam int TCCIRQ_FILTER_LEN = 4;

    // Complete state of the block
    typedef struct packed {
        logic [7:0]                    ctrl_a;
        logic [7:0]                    ctrl_b;
        logic [7:0]                    mask;
        logic [7:0]                    flags;
        logic [15:0]                   capture;
        logic [15:0]                   cmp_a;
        logic [15:0]                   cmp_b;
        logic [15:0]                   cmp_a_buf;
        logic [15:0]                   cmp_b_buf;
        logic [15:0]                   prev_count;
        logic                          pin_a;
        logic                          pin_b;
        logic                          icp_meta;
        logic                          icp_sync;
        logic                          acmp_meta;
        logic                          acmp_sync;
        logic [TCCIRQ_FILTER_LEN-1:0]  hist;
        logic                          filt_lvl;
        logic                          prev_lvl;
        logic [31:0]                   prdata;
    } tccirq_state_type;
endpackage

//--- rtl/tccirq_top.sv
// Timer1 capture/compare pin logic, PWM select and shared timer interrupt flags behind APB
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module tccirq_top
    import tccirq_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [15:0] t1_count_in,
    input  wire logic        t1_overflow_in,
    input  wire logic        t0_overflow_in,
    input  wire logic        t2_cmp_match_in,
    input  wire logic        t2_overflow_in,
    input  wire logic        global_irq_enable_in,
    input  wire logic        irq_ack_in,
    input  wire logic [3:0]  irq_ack_vector_in,
    output logic             irq_req_out,
    output logic      [3:0]  irq_vector_out,
    input  wire logic        capture_input_pin_in,
    input  wire logic        comparator_out_in,
    input  wire logic        comparator_capture_enable_in,
    input  wire logic        cmp_a_dir_in,
    input  wire logic        cmp_b_dir_in,
    output logic             cmp_a_output_pin_out,
    output logic             cmp_a_output_pin_oe_out,
    output logic             cmp_b_output_pin_out,
    output logic             cmp_b_output_pin_oe_out
);

    tccirq_state_type state_q;
    tccirq_state_type state_d;

    logic [7:0]  reg_idx;
    logic        addr_hit;
    logic        wr_acc;
    logic        rd_setup;
    logic [7:0]  wbyte;
    logic [1:0]  mode_a;
    logic [1:0]  mode_b;
    logic [1:0]  pwm_sel;
    logic        pwm_on;
    logic [15:0] width_mask;
    logic [15:0] cnt_m;
    logic        match_a;
    logic        match_b;
    logic        cap_level;
    logic        trigger;
    logic [7:0]  set_ev;
    logic [7:0]  clr_ev;
    logic [7:0]  pending;
    logic [7:0]  rd_byte;

    // APB decode; slave always ready, bad address flagged during access
    assign reg_idx  = paddr_in[9:2];
    assign addr_hit = (paddr_in[31:10] == 22'h000000) && (paddr_in[1:0] == 2'h0) &&
                      (reg_idx == TCCIRQ_IDX_CTRL_A || reg_idx == TCCIRQ_IDX_CTRL_B ||
                       reg_idx == TCCIRQ_IDX_MASK || reg_idx == TCCIRQ_IDX_FLAGS ||
                       reg_idx == TCCIRQ_IDX_CAPT_LO || reg_idx == TCCIRQ_IDX_CAPT_HI ||
                       reg_idx == TCCIRQ_IDX_CMPA_LO || reg_idx == TCCIRQ_IDX_CMPA_HI ||
                       reg_idx == TCCIRQ_IDX_CMPB_LO || reg_idx == TCCIRQ_IDX_CMPB_HI);
    assign wr_acc   = psel_in && penable_in && pwrite_in && addr_hit && pstrb_in[0];
    assign rd_setup = psel_in && !penable_in && !pwrite_in;
    assign wbyte    = pwdata_in[7:0];
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_hit;
    assign prdata_out  = state_q.prdata;

    // Control field views
    assign mode_a  = state_q.ctrl_a[TCCIRQ_CMPA_MODE_HI:TCCIRQ_CMPA_MODE_LO];
    assign mode_b  = state_q.ctrl_a[TCCIRQ_CMPB_MODE_HI:TCCIRQ_CMPB_MODE_LO];
    assign pwm_sel = state_q.ctrl_a[TCCIRQ_PWM_SEL_HI:TCCIRQ_PWM_SEL_LO];
    assign pwm_on  = (pwm_sel != TCCIRQ_PWM_OFF);

    // Counter width follows the PWM resolution
    always_comb begin
        case (pwm_sel)
            TCCIRQ_PWM_OFF: width_mask = 16'hFFFF;
            TCCIRQ_PWM_8:   width_mask = TCCIRQ_MASK_8;
            TCCIRQ_PWM_9:   width_mask = TCCIRQ_MASK_9;
            default:        width_mask = TCCIRQ_MASK_10;
        endcase
    end
    assign cnt_m = t1_count_in & width_mask;

    // Compare events: count arrives at the compare value
    assign match_a = (t1_count_in == state_q.cmp_a) && (t1_count_in != state_q.prev_count);
    assign match_b = (t1_count_in == state_q.cmp_b) && (t1_count_in != state_q.prev_count);

    // Capture source select between pin and comparator
    assign cap_level = comparator_capture_enable_in ? state_q.acmp_sync : state_q.icp_sync;

    // Capture trigger, filtered or first sampled edge
    always_comb begin
        if (state_q.ctrl_b[TCCIRQ_NOISE_EN]) begin
            trigger = (&state_q.hist == state_q.ctrl_b[TCCIRQ_EDGE_SEL]) &&
                      (|state_q.hist == state_q.ctrl_b[TCCIRQ_EDGE_SEL]) &&
                      (state_q.filt_lvl != state_q.ctrl_b[TCCIRQ_EDGE_SEL]);
        end else begin
            trigger = (cap_level != state_q.prev_lvl) &&
                      (cap_level == state_q.ctrl_b[TCCIRQ_EDGE_SEL]);
        end
    end

    // Hardware flag set events
    always_comb begin
        set_ev = 8'h00;
        set_ev[TCCIRQ_B_T2_CMP]  = t2_cmp_match_in;
        set_ev[TCCIRQ_B_T2_OVF]  = t2_overflow_in;
        set_ev[TCCIRQ_B_CAPTURE] = trigger;
        set_ev[TCCIRQ_B_CMP_A]   = match_a;
        set_ev[TCCIRQ_B_CMP_B]   = match_b;
        set_ev[TCCIRQ_B_T1_OVF]  = pwm_on ? ((state_q.prev_count & width_mask) == 16'h0000 && cnt_m != 16'h0000)
                                          : t1_overflow_in;
        set_ev[TCCIRQ_B_T0_OVF]  = t0_overflow_in;
    end

    // Clears from vector execution or a written one
    always_comb begin
        clr_ev = 8'h00;
        for (int i = 0; i < 8; i++) begin
            clr_ev[i] = (irq_ack_in && irq_ack_vector_in == TCCIRQ_VEC_TAB[i] && TCCIRQ_VEC_TAB[i] != TCCIRQ_VEC_NONE) ||
                        (wr_acc && reg_idx == TCCIRQ_IDX_FLAGS && wbyte[i] && TCCIRQ_FLAGS_RW[i]);
        end
    end

    // Request the highest-priority pending vector (lowest number)
    assign pending = state_q.flags & state_q.mask & {8{global_irq_enable_in}};
    always_comb begin
        irq_vector_out = TCCIRQ_VEC_NONE;
        for (int i = 0; i < 8; i++) begin
            if (pending[i]) begin
                irq_vector_out = TCCIRQ_VEC_TAB[i];
            end
        end
    end
    assign irq_req_out = |pending;

    // Register read mux
    always_comb begin
        case (reg_idx)
            TCCIRQ_IDX_CTRL_A:  rd_byte = state_q.ctrl_a & TCCIRQ_CTRL_A_RW;
            TCCIRQ_IDX_CTRL_B:  rd_byte = state_q.ctrl_b & TCCIRQ_CTRL_B_RW;
            TCCIRQ_IDX_MASK:    rd_byte = state_q.mask & TCCIRQ_MASK_RW;
            TCCIRQ_IDX_FLAGS:   rd_byte = state_q.flags & TCCIRQ_FLAGS_RW;
            TCCIRQ_IDX_CAPT_LO: rd_byte = state_q.capture[7:0];
            TCCIRQ_IDX_CAPT_HI: rd_byte = state_q.capture[15:8];
            TCCIRQ_IDX_CMPA_LO: rd_byte = state_q.cmp_a[7:0];
            TCCIRQ_IDX_CMPA_HI: rd_byte = state_q.cmp_a[15:8];
            TCCIRQ_IDX_CMPB_LO: rd_byte = state_q.cmp_b[7:0];
            TCCIRQ_IDX_CMPB_HI: rd_byte = state_q.cmp_b[15:8];
            default:            rd_byte = TCCIRQ_RST_BYTE;
        endcase
    end

    // Next-state logic
    always_comb begin
        state_d = state_q;

        // Synchronisers and capture sampling history
        state_d.icp_meta  = capture_input_pin_in;
        state_d.icp_sync  = state_q.icp_meta;
        state_d.acmp_meta = comparator_out_in;
        state_d.acmp_sync = state_q.acmp_meta;
        state_d.prev_lvl  = cap_level;
        state_d.hist      = {state_q.hist[TCCIRQ_FILTER_LEN-2:0], cap_level};
        if (&state_q.hist) begin
            state_d.filt_lvl = 1'b1;
        end else if (!(|state_q.hist)) begin
            state_d.filt_lvl = 1'b0;
        end
        state_d.prev_count = t1_count_in;

        // Capture of the running count
        if (trigger) begin
            state_d.capture = t1_count_in;
        end

        // Flags: a set in the same cycle as a clear wins
        for (int i = 0; i < 8; i++) begin
            state_d.flags[i] = TCCIRQ_FLAGS_RW[i] && (set_ev[i] || (state_q.flags[i] && !clr_ev[i]));
        end

        // Register writes at the access phase
        if (wr_acc) begin
            case (reg_idx)
                TCCIRQ_IDX_CTRL_A:  state_d.ctrl_a = wbyte & TCCIRQ_CTRL_A_RW;
                TCCIRQ_IDX_CTRL_B:  state_d.ctrl_b = wbyte & TCCIRQ_CTRL_B_RW;
                TCCIRQ_IDX_MASK:    state_d.mask   = wbyte & TCCIRQ_MASK_RW;
                TCCIRQ_IDX_CMPA_LO: state_d.cmp_a[7:0]  = wbyte;
                TCCIRQ_IDX_CMPA_HI: state_d.cmp_a[15:8] = wbyte;
                TCCIRQ_IDX_CMPB_LO: state_d.cmp_b[7:0]  = wbyte;
                TCCIRQ_IDX_CMPB_HI: state_d.cmp_b[15:8] = wbyte;
                default:            state_d.ctrl_b = state_q.ctrl_b;
            endcase
        end

        // PWM compare values reload at the counter bottom so pulses never glitch
        if (!pwm_on || cnt_m == 16'h0000) begin
            state_d.cmp_a_buf = state_q.cmp_a & width_mask;
            state_d.cmp_b_buf = state_q.cmp_b & width_mask;
        end

        // Compare output pins
        if (pwm_on) begin
            state_d.pin_a = (mode_a == TCCIRQ_OM_SET) ? (cnt_m >= state_q.cmp_a_buf)
                                                       : (cnt_m < state_q.cmp_a_buf);
            state_d.pin_b = (mode_b == TCCIRQ_OM_SET) ? (cnt_m >= state_q.cmp_b_buf)
                                                       : (cnt_m < state_q.cmp_b_buf);
        end else begin
            if (match_a) begin
                case (mode_a)
                    TCCIRQ_OM_TOGGLE: state_d.pin_a = !state_q.pin_a;
                    TCCIRQ_OM_CLEAR:  state_d.pin_a = 1'b0;
                    TCCIRQ_OM_SET:    state_d.pin_a = 1'b1;
                    default:          state_d.pin_a = state_q.pin_a;
                endcase
            end
            if (match_b) begin
                case (mode_b)
                    TCCIRQ_OM_TOGGLE: state_d.pin_b = !state_q.pin_b;
                    TCCIRQ_OM_CLEAR:  state_d.pin_b = 1'b0;
                    TCCIRQ_OM_SET:    state_d.pin_b = 1'b1;
                    default:          state_d.pin_b = state_q.pin_b;
                endcase
            end
        end

        // Read data captured in the setup phase
        if (rd_setup) begin
            state_d.prdata = {24'h000000, rd_byte};
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Pins are driven only when a mode is set and the direction bit allows it
    assign cmp_a_output_pin_out    = state_q.pin_a;
    assign cmp_b_output_pin_out    = state_q.pin_b;
    assign cmp_a_output_pin_oe_out = (mode_a != TCCIRQ_OM_OFF) && cmp_a_dir_in;
    assign cmp_b_output_pin_oe_out = (mode_b != TCCIRQ_OM_OFF) && cmp_b_dir_in;

endmodule

//--- test/tccirq_cpu_model.sv
// Behavioural processor core that executes pending interrupt vectors
`timescale 1ns/1ps
module tccirq_cpu_model (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       enable_in,
    input  wire logic [3:0] delay_in,
    input  wire logic       irq_req_in,
    input  wire logic [3:0] irq_vector_in,
    output logic            ack_out,
    output logic      [3:0] ack_vector_out
);
    logic [4:0] wait_q = 5'h0;
    logic       cool_q = 1'h0;
    int         acks[$];
    // Wait delay_in cycles on a standing request, then execute the vector; skip the cycle after
    always @(posedge clk_in) begin
        ack_out <= 1'h0;
        ack_vector_out <= rstn_in ? ack_vector_out + 4'h5 : 4'h0;  // Changing pattern while no vector is executed
        cool_q <= rstn_in && ack_out;
        if (!rstn_in || !enable_in || !irq_req_in || ack_out || cool_q) begin
            wait_q <= 5'h0;
        end else if (wait_q >= {1'h0, delay_in}) begin
            ack_out <= 1'h1;
            ack_vector_out <= irq_vector_in;
            acks.push_back(int'(irq_vector_in));
            wait_q <= 5'h0;
        end else begin
            wait_q <= wait_q + 5'h1;
        end
    end
endmodule

//--- test/tccirq_properties.sv
// Port-level assertions for the timer capture/compare and interrupt block
`timescale 1ns/1ps
module tccirq_properties
    import tccirq_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        t0_overflow_in,
    input wire logic        global_irq_enable_in,
    input wire logic        irq_ack_in,
    input wire logic [3:0]  irq_ack_vector_in,
    input wire logic        irq_req_out,
    input wire logic [3:0]  irq_vector_out,
    input wire logic        cmp_a_dir_in,
    input wire logic        cmp_b_dir_in,
    input wire logic        cmp_a_output_pin_oe_out,
    input wire logic        cmp_b_output_pin_oe_out
);
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // Read setup cycle aimed at one register index
    sequence rd_s(logic [7:0] idx);
        psel_in && !penable_in && !pwrite_in && paddr_in == {22'h0, idx, 2'h0};
    endsequence
    // Vector 9 executed with no new Timer0 overflow in the same cycle
    sequence ack9_s;
        irq_ack_in && irq_ack_vector_in == 4'h9 && !t0_overflow_in;
    endsequence
    glob_gate_a: assert property (!global_irq_enable_in |-> !irq_req_out)
        else $error("request without global enable");
    vec_range_a: assert property (irq_req_out |-> irq_vector_out inside {[4'h3:4'h9]})
        else $error("vector out of range");
    ack_clear_a: assert property (ack9_s |=> irq_vector_out != 4'h9)
        else $error("flag kept after vector");
    rst_quiet_a: assert property ($rose(rstn_in) |-> !irq_req_out && !cmp_a_output_pin_oe_out)
        else $error("active output after reset");
    oe_dir_a: assert property ((!cmp_a_output_pin_oe_out || cmp_a_dir_in) && (!cmp_b_output_pin_oe_out || cmp_b_dir_in))
        else $error("pin driven without direction bit");
    rsvd_bit_a: assert property ((rd_s(TCCIRQ_IDX_MASK) or rd_s(TCCIRQ_IDX_FLAGS)) |=> !prdata_out[1])
        else $error("bit 1 reads one");
    rsvd_ctla_a: assert property (rd_s(TCCIRQ_IDX_CTRL_A) |=> prdata_out[3:2] == 2'h0)
        else $error("control A reserved bits set");
    rsvd_ctlb_a: assert property (rd_s(TCCIRQ_IDX_CTRL_B) |=> prdata_out[5:4] == 2'h0)
        else $error("control B reserved bits set");
endmodule

//--- test/tccirq_top_tb.sv
// Self-checking bench for the timer capture/compare and interrupt block
`timescale 1ns/1ps
module tccirq_top_tb;
    import tccirq_pkg::*;
    logic        clk_in = 1'h0, rstn_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
    logic        t1_overflow_in = 1'h0, t0_overflow_in = 1'h0, t2_cmp_match_in = 1'h0, t2_overflow_in = 1'h0;
    logic        global_irq_enable_in = 1'h0, capture_input_pin_in = 1'h0, comparator_out_in = 1'h0;
    logic        comparator_capture_enable_in = 1'h0, cmp_a_dir_in = 1'h1, cmp_b_dir_in = 1'h1, cpu_en = 1'h0;
    logic        irq_ack_in, pready_out, pslverr_out, irq_req_out, err, pin_exp;
    logic        cmp_a_output_pin_out, cmp_a_output_pin_oe_out, cmp_b_output_pin_out, cmp_b_output_pin_oe_out;
    logic [31:0] paddr_in = 32'h0, pwdata_in = 32'h0, prdata_out, rd;
    logic [15:0] t1_count_in = 16'h0, cap_exp = 16'h0, v;
    logic [3:0]  pstrb_in = 4'hF, dly = 4'h0, irq_ack_vector_in, irq_vector_out;
    logic [7:0]  ix [4] = '{TCCIRQ_IDX_CTRL_A, TCCIRQ_IDX_CTRL_B, TCCIRQ_IDX_MASK, TCCIRQ_IDX_FLAGS};
    logic [7:0]  rw [4] = '{8'hF3, 8'hCF, 8'hFD, 8'h00};
    int          bad_count = 0, cmp_count = 0, seed = 91, i, j, m, b;
    int          exp_q[$];
    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;
    tccirq_top uut (.*);
    tccirq_cpu_model cpu (.clk_in(clk_in), .rstn_in(rstn_in), .enable_in(cpu_en), .delay_in(dly),
        .irq_req_in(irq_req_out), .irq_vector_in(irq_vector_out), .ack_out(irq_ack_in),
        .ack_vector_out(irq_ack_vector_in));
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // One APB transfer; data and error are taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        psel_in <= 1'h1;
        pwrite_in <= wr;
        paddr_in <= {22'h0, idx, 2'h0};
        pwdata_in <= {24'h0, wd};
        tick(1);
        penable_in <= 1'h1;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (pready_out !== 1'h1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            conclude;
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
        tick(1);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'h1, idx, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 8'h0);
        chk(what, exp, rd);
    endtask
    // Count up by one per cycle onto every value from 1 to top
    task automatic sweep(input logic [15:0] top);
        for (int c = 1; c <= int'(top); c++) begin
            t1_count_in <= 16'(c);
            tick(1);
        end
        tick(2);
    endtask
    // Move the capture source with a fresh count, optionally only as a short glitch on the pin
    task automatic cap(input logic [7:0] cb, input logic cmp, input logic lvl, input logic take);
        m = $random(seed);
        wr(TCCIRQ_IDX_CTRL_B, cb);
        t1_count_in <= m[15:0];
        comparator_capture_enable_in <= cmp;
        capture_input_pin_in <= cmp ? capture_input_pin_in : lvl;
        comparator_out_in <= cmp ? lvl : comparator_out_in;
        tick(3);
        capture_input_pin_in <= take ? capture_input_pin_in : ~lvl;
        tick(9);
        if (take)
            cap_exp = m[15:0];
        rchk("capt lo", TCCIRQ_IDX_CAPT_LO, {24'h0, cap_exp[7:0]});
        rchk("capt hi", TCCIRQ_IDX_CAPT_HI, {24'h0, cap_exp[15:8]});
    endtask
    // Main sequence
    initial begin
        tick(3);
        rstn_in <= 1'h1;
        tick(1);
        for (i = 0; i < 4; i++) begin
            rchk("reset", ix[i], 32'h0);
            wr(ix[i], 8'hFF);
            rchk("rw bits", ix[i], {24'h0, rw[i]});
        end
        rchk("unmapped", 8'h3F, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        wr(TCCIRQ_IDX_MASK, 8'h00);
        wr(TCCIRQ_IDX_CTRL_A, 8'h00);
        $display("registers done");
        m = $random(seed);
        v = {8'h00, m[7:0]} | 16'h0010;
        for (i = 0; i < 2; i++) begin
            wr(i ? TCCIRQ_IDX_CMPB_LO : TCCIRQ_IDX_CMPA_LO, v[7:0]);
            for (j = 0; j < 3; j++) begin
                b = (j + 1) % 3 + 1;
                wr(TCCIRQ_IDX_CTRL_A, i ? 8'(b << 4) : 8'(b << 6));
                sweep(v + 16'h2);
                pin_exp = (b == 1) ? ~pin_exp : b[0];
                chk("pin", {31'h0, pin_exp}, {31'h0, i ? cmp_b_output_pin_out : cmp_a_output_pin_out});
                chk("oe", 32'h1, {31'h0, i ? cmp_b_output_pin_oe_out : cmp_a_output_pin_oe_out});
            end
            rchk("cmp flag", TCCIRQ_IDX_FLAGS, i ? 32'h18 : 32'h10);
        end
        cmp_b_dir_in <= 1'h0;
        tick(1);
        chk("oe dir", 32'h0, {31'h0, cmp_b_output_pin_oe_out});
        cmp_b_dir_in <= 1'h1;
        $display("compare done");
        for (m = 1; m < 4; m++) begin
            wr(TCCIRQ_IDX_CTRL_A, 8'(m));
            t1_count_in <= 16'h0;
            wr(TCCIRQ_IDX_FLAGS, 8'hFF);
            t1_count_in <= 16'h1;
            tick(3);
            rchk("pwm ovf", TCCIRQ_IDX_FLAGS, 32'h04);
        end
        // 8-bit PWM, pin A high from the compare value up, pin B low from it up
        wr(TCCIRQ_IDX_CTRL_A, 8'hE1);
        for (j = 0; j < 2; j++) begin
            t1_count_in <= v - 16'(1 - j);
            tick(2);
            chk("pwm a", {31'h0, j[0]}, {31'h0, cmp_a_output_pin_out});
            chk("pwm b", {31'h0, ~j[0]}, {31'h0, cmp_b_output_pin_out});
        end
        wr(TCCIRQ_IDX_CTRL_A, 8'h00);
        $display("pwm done");
        cap(8'h40, 1'h0, 1'h1, 1'h1);
        cap(8'h00, 1'h0, 1'h0, 1'h1);
        cap(8'hC0, 1'h0, 1'h1, 1'h0);
        cap(8'hC0, 1'h0, 1'h1, 1'h1);
        cap(8'h40, 1'h1, 1'h1, 1'h1);
        cap(8'h00, 1'h1, 1'h0, 1'h1);
        $display("capture done");
        wr(TCCIRQ_IDX_FLAGS, 8'hFF);
        rchk("flags clr", TCCIRQ_IDX_FLAGS, 32'h0);
        wr(TCCIRQ_IDX_MASK, 8'hFF);
        {t2_cmp_match_in, t2_overflow_in, t1_overflow_in, t0_overflow_in} <= 4'hF;
        tick(1);
        {t2_cmp_match_in, t2_overflow_in, t1_overflow_in, t0_overflow_in} <= 4'h0;
        tick(2);
        chk("req gated", 32'h0, {31'h0, irq_req_out});
        rchk("flags set", TCCIRQ_IDX_FLAGS, 32'hC5);
        wr(TCCIRQ_IDX_FLAGS, 8'h80);
        m = 'h45;
        rchk("w1c", TCCIRQ_IDX_FLAGS, 32'(m));
        for (b = 7; b >= 0; b--)
            if (m[b])
                exp_q.push_back(b ? 10 - b : 9);
        dly <= 4'($random(seed));
        cpu_en <= 1'h1;
        global_irq_enable_in <= 1'h1;
        for (i = 0; i < 300 && (cpu.acks.size() < 3 || irq_req_out !== 1'h0); i++)
            tick(1);
        if (i >= 300)
            bad_count++;
        for (i = 0; i < 3; i++)
            chk("vector", 32'(exp_q[i]), 32'(cpu.acks[i]));
        rchk("flags done", TCCIRQ_IDX_FLAGS, 32'h0);
        $display("interrupts done");
        conclude;
    end
endmodule
bind tccirq_top tccirq_properties prop_chk (.*);
